// [perf_global_pkg.sv]
// Register map and field layout of the global counter control block
package perf_global_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  // Register indices; byte address of low word is four times the index
  localparam logic [11:0] STATUS_IDX      = 12'h038e;
  localparam logic [11:0] OVF_CLEAR_IDX   = 12'h0390;
  localparam logic [11:0] GLOBAL_EN_IDX   = 12'h03bf;
  localparam logic [11:0] IRQ_MASK_IDX    = 12'h03c1;
  localparam logic [11:0] SAMPLE_EN_IDX   = 12'h03f1;
  // Field positions
  localparam int          GEN0_BIT        = 0;
  localparam int          GEN1_BIT        = 1;
  localparam int          FIX0_BIT        = 32;
  localparam int          FIX1_BIT        = 33;
  localparam int          FIX2_BIT        = 34;
  localparam int          BUF_OVF_BIT     = 62;
  localparam int          COND_CHG_BIT    = 63;
  localparam int          SAMPLE_EN_BIT   = 0;
  // Implemented bits
  localparam logic [63:0] GEN_MASK        = 64'h0000_0000_0000_0003;
  localparam logic [63:0] FIX_MASK        = 64'h0000_0007_0000_0000;
  localparam logic [63:0] FLAG_MASK       = 64'hc000_0000_0000_0000;
  localparam logic [63:0] SAMPLE_MASK     = 64'h0000_0000_0000_0001;
  // Reset values
  localparam logic [63:0] GLOBAL_EN_RST   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STATUS_RST      = 64'h0000_0000_0000_0000;
  localparam logic [63:0] IRQ_MASK_RST    = 64'h0000_0000_0000_0000;
  localparam logic [63:0] SAMPLE_EN_RST   = 64'h0000_0000_0000_0000;
endpackage : perf_global_pkg

// [perf_counter_global_control.sv]
// Global enable, overflow status and clear, sampling enable, interrupt
`timescale 1ns/10ps

module perf_counter_global_control #(
  parameter int VERSION_LEVEL = 2
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  general_privilege_enable,
  input  wire logic [2:0]  fixed_privilege_enable,
  input  wire logic [2:0]  fixed_interrupt_enable,
  input  wire logic [1:0]  general_overflow_event,
  input  wire logic [2:0]  fixed_overflow_event,
  input  wire logic        buffer_overflow_event,
  output logic      [1:0]  general_count_enable,
  output logic      [2:0]  fixed_count_enable,
  output logic             precise_event_sampling,
  output logic             perf_monitor_interrupt
);

  // Version level zero has no counters to control
  if (VERSION_LEVEL < 1) begin : g_bad_version
    $error("VERSION_LEVEL must be at least 1");
  end

  // Port widths are fixed at the bus sizes of the package
  if (perf_global_pkg::ADDR_W != 12 ||
      perf_global_pkg::DATA_W != 32) begin : g_bad_bus
    $error("bus widths must be 12 and 32 bits");
  end

  // Flag positions must lie inside the 64-bit registers
  if (perf_global_pkg::FIX2_BIT > 63 ||
      perf_global_pkg::COND_CHG_BIT > 63) begin : g_bad_layout
    $error("flag positions must lie within 64 bits");
  end

  localparam logic [63:0] FIX_PRESENT =
    (VERSION_LEVEL > 1) ? perf_global_pkg::FIX_MASK : 64'h0000_0000_0000_0000;
  localparam logic [63:0] EN_BITS =
    perf_global_pkg::GEN_MASK | FIX_PRESENT;
  localparam logic [63:0] FLAG_BITS =
    perf_global_pkg::GEN_MASK | FIX_PRESENT | perf_global_pkg::FLAG_MASK;

  typedef enum logic {bus_idle, bus_answer} bus_state_t;

  logic [63:0] global_counter_enable;
  logic [63:0] global_overflow_status;
  logic [63:0] interrupt_mask;
  logic [63:0] precise_sampling_enable;
  logic [63:0] next_status;
  logic [63:0] status_set;
  logic [63:0] status_clear;
  logic [63:0] pmi_gate;
  logic [63:0] write_value;
  logic [63:0] lane_mask;
  logic [11:0] word_index;
  logic        high_word;
  logic        request;
  logic        access;
  logic [11:0] raw_index;
  logic [63:0] read_value;
  logic [63:0] next_enable;
  logic [63:0] next_mask;
  logic [63:0] next_sample;
  logic        sel_status;
  logic        sel_clear;
  logic        sel_enable;
  logic        sel_mask;
  logic        sel_sample;
  logic        write_ok;
  logic        read_start;
  logic        wr_clear;
  logic        wr_enable;
  logic        wr_mask;
  logic        wr_sample;
  bus_state_t  bus_state;
  bus_state_t  next_bus_state;

  // Byte enables spread to a 64-bit lane mask for the addressed half
  function automatic logic [63:0] lanes(input logic [3:0] be,
                                        input logic       hi);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    lanes = hi ? {m, 32'h0000_0000} : {32'h0000_0000, m};
  endfunction : lanes

  // Reads one 32-bit half of a 64-bit register
  function automatic logic [31:0] half(input logic [63:0] r,
                                       input logic        hi);
    half = hi ? r[63:32] : r[31:0];
  endfunction : half

  // Writes masked bytes into the implemented bits of a register
  function automatic logic [63:0] merge(input logic [63:0] old,
                                        input logic [63:0] val,
                                        input logic [63:0] lm,
                                        input logic [63:0] impl);
    merge = ((old & ~lm) | (val & lm)) & impl;
  endfunction : merge

  // True where a word index falls on either half of a register
  function automatic logic covers(input logic [11:0] wi,
                                  input logic [11:0] base);
    covers = (wi == base) || (wi == base + 12'h001);
  endfunction : covers

  // Low word index of the register holding a word, all ones if none
  function automatic logic [11:0] base_of(input logic [11:0] wi);
    base_of = 12'hfff;
    if (covers(wi, perf_global_pkg::STATUS_IDX)) begin
      base_of = perf_global_pkg::STATUS_IDX;
    end
    if (covers(wi, perf_global_pkg::OVF_CLEAR_IDX)) begin
      base_of = perf_global_pkg::OVF_CLEAR_IDX;
    end
    if (covers(wi, perf_global_pkg::GLOBAL_EN_IDX)) begin
      base_of = perf_global_pkg::GLOBAL_EN_IDX;
    end
    if (covers(wi, perf_global_pkg::IRQ_MASK_IDX)) begin
      base_of = perf_global_pkg::IRQ_MASK_IDX;
    end
    if (covers(wi, perf_global_pkg::SAMPLE_EN_IDX)) begin
      base_of = perf_global_pkg::SAMPLE_EN_IDX;
    end
  endfunction : base_of

  // Low word at a register's index, high word at index plus one
  always_comb begin
    raw_index   = {2'b00, avs_address[11:2]};
    word_index  = base_of(raw_index);
    high_word   = raw_index != word_index;
    lane_mask   = lanes(avs_byteenable, high_word);
    write_value = {avs_writedata, avs_writedata};
    request     = avs_read | avs_write;
    access      = request & ~avs_waitrequest;
  end

  // Register selects and access strobes
  always_comb begin
    sel_status = word_index == perf_global_pkg::STATUS_IDX;
    sel_clear  = word_index == perf_global_pkg::OVF_CLEAR_IDX;
    sel_enable = word_index == perf_global_pkg::GLOBAL_EN_IDX;
    sel_mask   = word_index == perf_global_pkg::IRQ_MASK_IDX;
    sel_sample = word_index == perf_global_pkg::SAMPLE_EN_IDX;
    write_ok   = access & avs_write;
    read_start = avs_read & avs_waitrequest;
    wr_clear   = write_ok & sel_clear;
    wr_enable  = write_ok & sel_enable;
    wr_mask    = write_ok & sel_mask;
    wr_sample  = write_ok & sel_sample;
  end

  // Read-back value; the clear register and holes read zero
  always_comb begin
    read_value = 64'h0000_0000_0000_0000;
    if (sel_status) begin
      read_value = global_overflow_status;
    end
    if (sel_enable) begin
      read_value = global_counter_enable;
    end
    if (sel_mask) begin
      read_value = interrupt_mask;
    end
    if (sel_sample) begin
      read_value = precise_sampling_enable;
    end
  end

  // Next values of the writable registers
  always_comb begin
    next_enable = merge(global_counter_enable, write_value, lane_mask,
                        EN_BITS);
    next_mask   = merge(interrupt_mask, write_value, lane_mask, FLAG_BITS);
    next_sample = merge(precise_sampling_enable, write_value, lane_mask,
                        perf_global_pkg::SAMPLE_MASK);
  end

  // Bus handshake: one answer cycle after each request
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      bus_idle: begin
        if (request) begin
          next_bus_state = bus_answer;
        end
      end
      bus_answer: begin
        next_bus_state = bus_idle;
      end
    endcase
  end

  // Bus state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= bus_idle;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Waitrequest low only in the answer cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= next_bus_state != bus_answer;
    end
  end

  // Read data valid at the edge that sees waitrequest low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (read_start) begin
      avs_readdata <= half(read_value, high_word);
    end
  end

  // Global enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_counter_enable <= perf_global_pkg::GLOBAL_EN_RST;
    end else if (wr_enable) begin
      global_counter_enable <= next_enable;
    end
  end

  // Interrupt mask register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_mask <= perf_global_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      interrupt_mask <= next_mask;
    end
  end

  // Precise sampling enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      precise_sampling_enable <= perf_global_pkg::SAMPLE_EN_RST;
    end else if (wr_sample) begin
      precise_sampling_enable <= next_sample;
    end
  end

  // Status set and clear terms
  always_comb begin
    status_set = 64'h0000_0000_0000_0000;
    status_set[perf_global_pkg::GEN0_BIT] = general_overflow_event[0];
    status_set[perf_global_pkg::GEN1_BIT] = general_overflow_event[1];
    status_set[perf_global_pkg::FIX0_BIT] = fixed_overflow_event[0];
    status_set[perf_global_pkg::FIX1_BIT] = fixed_overflow_event[1];
    status_set[perf_global_pkg::FIX2_BIT] = fixed_overflow_event[2];
    status_set[perf_global_pkg::BUF_OVF_BIT] = buffer_overflow_event;
    status_set = status_set & FLAG_BITS;
    status_set[perf_global_pkg::COND_CHG_BIT] =
      |(status_set & ~global_overflow_status);
    status_clear = 64'h0000_0000_0000_0000;
    if (wr_clear) begin
      status_clear = write_value & lane_mask & FLAG_BITS;
    end
    next_status = ((global_overflow_status & ~status_clear) | status_set)
                  & FLAG_BITS;
  end

  // Sticky overflow flags, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_overflow_status <= perf_global_pkg::STATUS_RST;
    end else begin
      global_overflow_status <= next_status;
    end
  end

  // General counter enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_count_enable <= 2'b00;
    end else begin
      general_count_enable <= global_counter_enable[1:0] &
                              general_privilege_enable;
    end
  end

  // Fixed counter enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fixed_count_enable <= 3'b000;
    end else begin
      fixed_count_enable <= global_counter_enable[34:32] &
                            fixed_privilege_enable;
    end
  end

  // Sampling enable output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      precise_event_sampling <= 1'b0;
    end else begin
      precise_event_sampling <=
        precise_sampling_enable[perf_global_pkg::SAMPLE_EN_BIT];
    end
  end

  // Fixed counter flags interrupt only with their own enable
  always_comb begin
    pmi_gate = 64'hffff_ffff_ffff_ffff;
    pmi_gate[perf_global_pkg::FIX0_BIT] = fixed_interrupt_enable[0];
    pmi_gate[perf_global_pkg::FIX1_BIT] = fixed_interrupt_enable[1];
    pmi_gate[perf_global_pkg::FIX2_BIT] = fixed_interrupt_enable[2];
  end

  // Level interrupt
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      perf_monitor_interrupt <= 1'b0;
    end else begin
      perf_monitor_interrupt <= |(next_status & interrupt_mask &
                                  pmi_gate);
    end
  end

endmodule : perf_counter_global_control

// [perf_global_checker.sv]
// Port-level assertions for the global counter control block
`timescale 1ns/10ps
module perf_global_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  general_privilege_enable,
  input wire logic [2:0]  fixed_privilege_enable,
  input wire logic [1:0]  general_overflow_event,
  input wire logic [2:0]  fixed_overflow_event,
  input wire logic        buffer_overflow_event,
  input wire logic [1:0]  general_count_enable,
  input wire logic [2:0]  fixed_count_enable,
  input wire logic        precise_event_sampling,
  input wire logic        perf_monitor_interrupt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire       ack = !avs_waitrequest;
  wire [9:0] idx = avs_address[11:2];
  one_wait_a: assert property ((avs_read || avs_write) && !ack |=> ack)
    else $error("no answer after one wait cycle");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("waitrequest low longer than one cycle");
  ack_cause_a: assert property (ack |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  gen_gate_a: assert property (
    (general_count_enable & ~$past(general_privilege_enable)) == 2'b00)
    else $error("general count enable without privilege enable");
  fix_gate_a: assert property (
    (fixed_count_enable & ~$past(fixed_privilege_enable)) == 3'b000)
    else $error("fixed count enable without privilege enable");
  sample_write_a: assert property ($changed(precise_event_sampling)
    |-> $past(avs_write && ack && idx == 10'h3f1, 2))
    else $error("sampling enable changed without a write");
  irq_cause_a: assert property ($rose(perf_monitor_interrupt) |->
    $past(|general_overflow_event || |fixed_overflow_event ||
    buffer_overflow_event || avs_write) || $past(avs_write && ack, 2))
    else $error("interrupt rose without event or write");
  irq_clear_a: assert property ($fell(perf_monitor_interrupt)
    |-> $past(avs_write && ack) || $past(avs_write && ack, 2))
    else $error("interrupt fell without a write");
  clear_reads_a: assert property (avs_read && ack && idx[9:1] == 9'h1c8
    |-> avs_readdata == 32'h0000_0000)
    else $error("overflow clear register read not zero");
  status_rsvd_a: assert property (avs_read && ack && idx == 10'h38f
    |-> (avs_readdata & 32'h3fff_fff8) == 32'h0000_0000)
    else $error("status reserved bits not zero");
endmodule : perf_global_checker

bind perf_counter_global_control perf_global_checker chk_u (.*);

// [tb.sv]
// Self-checking bench for the global counter control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] avs_address = 12'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  general_privilege_enable = 2'b01;
  logic [2:0]  fixed_privilege_enable = 3'b101;
  logic [2:0]  fixed_interrupt_enable = 3'b000;
  logic [1:0]  general_overflow_event = 2'b00;
  logic [2:0]  fixed_overflow_event = 3'b000;
  logic        buffer_overflow_event = 1'b0;
  logic [1:0]  general_count_enable;
  logic [2:0]  fixed_count_enable;
  logic        precise_event_sampling;
  logic        perf_monitor_interrupt;
  logic [31:0] q;
  logic [63:0] exp_st;
  int          num_errors = 0;
  int          tests_run = 0;
  int          bits [7] = '{0, 1, 32, 33, 34, 62, 63};
  logic [11:0] regs [5] = '{12'h0e38, 12'h0e40, 12'h0efc, 12'h0f04, 12'h0fc4};
  perf_counter_global_control dut_u (.*);
  always #20 sys_clk = ~sys_clk;
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      $display("[ERR] bus answer exp %h got %h", 1'b0, avs_waitrequest);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd64(input logic [11:0] a, output logic [63:0] v);
    bus(a, 1'b0, 32'h0000_0000);
    v[31:0] = q;
    bus(a + 12'h0004, 1'b0, 32'h0000_0000);
    v[63:32] = q;
  endtask : rd64
  task automatic wr64(input logic [11:0] a, input logic [63:0] v);
    bus(a, 1'b1, v[31:0]);
    bus(a + 12'h0004, 1'b1, v[63:32]);
  endtask : wr64
  task automatic ev(input logic [1:0] g, input logic [2:0] f, input logic b);
    @(posedge sys_clk);
    general_overflow_event <= g;
    fixed_overflow_event <= f;
    buffer_overflow_event <= b;
    @(posedge sys_clk);
    general_overflow_event <= 2'b00;
    fixed_overflow_event <= 3'b000;
    buffer_overflow_event <= 1'b0;
    @(negedge sys_clk);
  endtask : ev
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
  initial begin
    logic [63:0] v;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    `CHK("idle waitrequest", 1'b1, avs_waitrequest)
    foreach (regs[i]) begin
      rd64(regs[i], v);
      `CHK("reset value", 64'h0000_0000_0000_0000, v)
    end
    bus(12'h0100, 1'b1, 32'hffff_ffff);
    bus(12'h0100, 1'b0, 32'h0000_0000);
    `CHK("unmapped read", 32'h0000_0000, q)
    wr64(12'h0efc, 64'h0000_0006_0000_0002);
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("gen enable and", 2'b00, general_count_enable)
    `CHK("fix enable and", 3'b100, fixed_count_enable)
    wr64(12'h0efc, '1);
    rd64(12'h0efc, v);
    `CHK("global enable", 64'h0000_0007_0000_0003, v)
    `CHK("gen count", 2'b01, general_count_enable)
    `CHK("fix count", 3'b101, fixed_count_enable)
    wr64(12'h0fc4, '1);
    rd64(12'h0fc4, v);
    `CHK("sample reg", 64'h0000_0000_0000_0001, v)
    `CHK("sampling out", 1'b1, precise_event_sampling)
    ev(2'b11, 3'b111, 1'b1);
    `CHK("irq masked", 1'b0, perf_monitor_interrupt)
    wr64(12'h0e40, 64'h3fff_fff8_ffff_fffc);
    wr64(12'h0e38, '1);
    wr64(12'h0f04, '1);
    exp_st = 64'hc000_0007_0000_0003;
    rd64(12'h0e38, v);
    `CHK("status set", exp_st, v)
    `CHK("irq unmasked", 1'b1, perf_monitor_interrupt)
    foreach (bits[k]) begin
      wr64(12'h0e40, 64'h0000_0000_0000_0001 << bits[k]);
      exp_st[bits[k]] = 1'b0;
      rd64(12'h0e38, v);
      `CHK("status clear", exp_st, v)
    end
    @(negedge sys_clk);
    `CHK("irq cleared", 1'b0, perf_monitor_interrupt)
    wr64(12'h0f04, 64'h0000_0001_0000_0000);
    ev(2'b00, 3'b001, 1'b0);
    `CHK("irq gated", 1'b0, perf_monitor_interrupt)
    wr64(12'h0e40, '1);
    fixed_interrupt_enable <= 3'b001;
    ev(2'b00, 3'b001, 1'b0);
    `CHK("irq fixed", 1'b1, perf_monitor_interrupt)
    wr64(12'h0e40, '1);
    @(negedge sys_clk);
    `CHK("irq fixed clear", 1'b0, perf_monitor_interrupt)
    stop_test();
  end
endmodule : tb
